/* File: rtl/tcv_pkg.sv */
// shared constants and types for the thermocouple channel value path
package tcv_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SIMVAL = 8'h04;
  localparam logic [7:0] OFS_SUBVAL = 8'h08;
  localparam logic [7:0] OFS_LIMLO = 8'h0C;
  localparam logic [7:0] OFS_START = 8'h10;
  localparam logic [7:0] OFS_END = 8'h14;
  localparam logic [7:0] OFS_LIMHI = 8'h18;
  localparam logic [7:0] OFS_FCLR = 8'h1C;
  localparam logic [7:0] OFS_CJRATIO = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQST = 8'h28;
  localparam logic [7:0] OFS_IRQMSK = 8'h2C;
  localparam logic [7:0] OFS_WORD = 8'h30;
  // control field positions
  localparam int CTRL_SIM = 0;
  localparam int CTRL_ERRLO = 1;
  localparam int CTRL_LFDEN = 3;
  localparam int CTRL_CJEXT = 4;
  localparam int CTRL_MODEN = 5;
  localparam int CTRL_W = 6;
  // channel word layout
  localparam int WORD_FAULT_BIT = 1;
  localparam logic [15:0] STAT_MASK = 16'h000F;
  // scaling defaults
  localparam logic [15:0] DEF_LIMLO = 16'h0000;
  localparam logic [15:0] DEF_START = 16'h2710;
  localparam logic [15:0] DEF_END = 16'hC350;
  localparam logic [15:0] DEF_LIMHI = 16'hEA60;
  localparam logic [15:0] DEF_CJRATIO = 16'h0014;
  localparam logic [15:0] DEF_FCLR = 16'h0000;
  localparam logic [15:0] PCT_FULL = 16'h8000;
  // interrupt bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_GOOD = 1;
  localparam int IRQ_WORD = 2;
  localparam int IRQ_W = 3;
  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {
    ERR_CURRENT = 2'b00,
    ERR_SUBST = 2'b01,
    ERR_LAST = 2'b10
  } tcv_errmode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW = 2'b10
  } tcv_tx_e;
endpackage : tcv_pkg

/* File: rtl/tcv_value_path.sv */
// thermocouple channel value path with ahb-lite register slave
// Summary of operation
// - normal mode forwards live measurement as process value.
// - simulation mode forwards configured simulated value instead.
// - current-value strategy passes field value unchanged during errors.
// - substitute strategy outputs configured replacement value during errors.
// - last-valid strategy holds last good measurement from before fault.
// - replacement values carry the invalid-data status.
// - enabled line fault monitoring flags fault and triggers strategy.
// - good reported only after configured count of clean cycles; with monitoring off the code reports good at the next sample.
// - one cold junction measurement inserted after every N measurements; the code requests none while external cold junction is selected.
// - output never below configured lower limit, default zero.
// - start of range maps to 0% point, default 10000.
// - end of range maps to 100% point, default 50000.
// - output never above configured upper limit, default 60000.
// - internal or external cold junction selectable.
// - channel active only while module enabled.
// - word bit 1 is the line fault flag.
// - status bits omitted when scaling lies outside 10000..50000.
// - word sent high byte first, then low byte.
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tcv_value_path
  import tcv_pkg::*;
#(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // measurement front end
  input wire logic measValid,
  input wire logic [DW-1:0] measPct,
  input wire logic measIsCj,
  input wire logic lineFault,
  output logic cjRequest,
  output logic cjExternal,
  // com unit byte stream
  input wire logic txReady,
  output logic txValid,
  output logic [7:0] txByte,
  output logic [DW-1:0] chanWord,
  output logic chanActive,
  output logic irq
);
  typedef struct packed {
    // configuration
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] simVal;
    logic [15:0] subVal;
    logic [15:0] limLo;
    logic [15:0] startPt;
    logic [15:0] endPt;
    logic [15:0] limHi;
    logic [15:0] clrCnt;
    logic [15:0] cjRatio;
    // measurement progress
    logic [15:0] tcCount;
    logic [15:0] goodCnt;
    logic faulted;
    logic [15:0] lastGood;
    logic [15:0] word;
    // interrupts and byte link
    logic [IRQ_W-1:0] irqSt;
    logic [IRQ_W-1:0] irqMsk;
    tcv_tx_e tx;
    logic cjReq;
    // bus address phase
    logic aValid;
    logic aWrite;
    logic [7:0] aAddr;
  } tcv_state_s;

  tcv_state_s s_r, s_nxt;

  // clamp a signed intermediate into the lo..hi window
  function automatic logic [15:0] clamp(input logic signed [33:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    logic signed [33:0] loS;
    logic signed [33:0] hiS;
    logic signed [33:0] r;
    loS = 34'(signed'({1'b0, lo}));
    hiS = 34'(signed'({1'b0, hi}));
    r = v;
    if (r < loS) begin
      r = loS;
    end
    if (r > hiS) begin
      r = hiS;
    end
    // limits are 16 bit, so the clamped value always fits
    clamp = r[15:0];
  endfunction : clamp

  // linear map of a 0..PCT_FULL fraction onto start..end
  // 34 bits keep a falling span and the product from wrapping
  function automatic logic [15:0] scale(input logic [15:0] pct,
      input logic [15:0] lo, input logic [15:0] st, input logic [15:0] en,
      input logic [15:0] hi);
    logic signed [33:0] span;
    logic signed [33:0] prod;
    logic signed [33:0] v;
    span = 34'(signed'({1'b0, en})) - 34'(signed'({1'b0, st}));
    prod = span * 34'(signed'({1'b0, pct}));
    v = 34'(signed'({1'b0, st})) + (prod >>> 15);
    scale = clamp(v, lo, hi);
  endfunction : scale

  // status nibble: bit 1 line fault, bit 0 invalid data
  function automatic logic [3:0] stat_bits(input logic flt,
      input logic inv);
    stat_bits = {2'b00, flt, inv} & STAT_MASK[3:0];
  endfunction : stat_bits

  // count plus this sample reaches its target; 17 bits, no wrap
  function automatic logic count_reached(input logic [15:0] cnt,
      input logic [15:0] need);
    logic [16:0] nxt;
    nxt = {1'b0, cnt} + 17'h0_0001;
    count_reached = nxt >= {1'b0, need};
  endfunction : count_reached

  logic [31:0] regRd;
  logic active;
  logic errNow;
  logic [15:0] rawVal;
  logic [15:0] outVal;
  logic invalid;
  logic statOk;
  logic [IRQ_W-1:0] irqEv;
  tcv_errmode_e errMode;

  assign errMode = tcv_errmode_e'(s_r.ctrl[CTRL_ERRLO +: 2]);
  assign active = s_r.ctrl[CTRL_MODEN];
  assign statOk = (s_r.startPt >= DEF_START) && (s_r.endPt <= DEF_END);

  always_comb begin
    regRd = 32'h0000_0000;
    if (s_r.aAddr == OFS_CTRL) begin
      regRd = 32'(s_r.ctrl);
    end else if (s_r.aAddr == OFS_SIMVAL) begin
      regRd = {16'h0000, s_r.simVal};
    end else if (s_r.aAddr == OFS_SUBVAL) begin
      regRd = {16'h0000, s_r.subVal};
    end else if (s_r.aAddr == OFS_LIMLO) begin
      regRd = {16'h0000, s_r.limLo};
    end else if (s_r.aAddr == OFS_START) begin
      regRd = {16'h0000, s_r.startPt};
    end else if (s_r.aAddr == OFS_END) begin
      regRd = {16'h0000, s_r.endPt};
    end else if (s_r.aAddr == OFS_LIMHI) begin
      regRd = {16'h0000, s_r.limHi};
    end else if (s_r.aAddr == OFS_FCLR) begin
      regRd = {16'h0000, s_r.clrCnt};
    end else if (s_r.aAddr == OFS_CJRATIO) begin
      regRd = {16'h0000, s_r.cjRatio};
    end else if (s_r.aAddr == OFS_STATUS) begin
      regRd = {29'h0000_0000, s_r.cjReq, s_r.faulted, active};
    end else if (s_r.aAddr == OFS_IRQST) begin
      regRd = 32'(s_r.irqSt);
    end else if (s_r.aAddr == OFS_IRQMSK) begin
      regRd = 32'(s_r.irqMsk);
    end else if (s_r.aAddr == OFS_WORD) begin
      regRd = {16'h0000, s_r.word};
    end
  end

  always_comb begin
    s_nxt = s_r;
    irqEv = '0;
    // front-end sample scaled into counts
    // start maps to 0% point
    rawVal = scale(16'(measPct), s_r.limLo, s_r.startPt, s_r.endPt,
        s_r.limHi);
    // a latched fault stays an error until its clean run ends
    // fault only counts with monitoring on
    errNow = s_r.ctrl[CTRL_LFDEN] && (lineFault || s_r.faulted);
    outVal = rawVal;
    invalid = 1'b0;
    if (s_r.ctrl[CTRL_SIM]) begin
      outVal = scale(s_r.simVal, s_r.limLo, s_r.startPt, s_r.endPt,
          s_r.limHi);
    end else if (errNow) begin
      case (errMode)
        ERR_CURRENT: begin
          outVal = rawVal;
        end
        ERR_SUBST: begin
          outVal = scale(s_r.subVal, s_r.limLo, s_r.startPt, s_r.endPt,
              s_r.limHi);
          invalid = 1'b1;
        end
        ERR_LAST: begin
          outVal = s_r.lastGood;
          invalid = 1'b1;
        end
        default: begin
          outVal = rawVal;
        end
      endcase
    end
    // live value in normal mode otherwise
    if (active && measValid && measIsCj) begin
      s_nxt.cjReq = 1'b0;
      s_nxt.tcCount = 16'h0000;
    end else if (active && measValid) begin
      if (!s_r.ctrl[CTRL_CJEXT] &&
          count_reached(s_r.tcCount, s_r.cjRatio)) begin
        s_nxt.cjReq = 1'b1;
      end
      s_nxt.tcCount = s_r.tcCount + 16'h0001;
      if (s_r.ctrl[CTRL_LFDEN] && lineFault) begin
        if (!s_r.faulted) begin
          irqEv[IRQ_FAULT] = 1'b1;
        end
        s_nxt.faulted = 1'b1;
        s_nxt.goodCnt = 16'h0000;
      end else if (s_r.faulted) begin
        if (count_reached(s_r.goodCnt, s_r.clrCnt) ||
            !s_r.ctrl[CTRL_LFDEN]) begin
          s_nxt.faulted = 1'b0;
          irqEv[IRQ_GOOD] = 1'b1;
        end else begin
          s_nxt.goodCnt = s_r.goodCnt + 16'h0001;
        end
      end else begin
        // only clean, unfaulted samples refresh the held value
        s_nxt.lastGood = rawVal;
      end
      s_nxt.word = outVal;
      if (statOk) begin
        // bit 1 is the fault flag
        s_nxt.word[3:0] = stat_bits(errNow, invalid);
      end
      irqEv[IRQ_WORD] = 1'b1;
      if (s_r.tx == ST_IDLE) begin
        s_nxt.tx = ST_HIGH;
      end
    end
    case (s_r.tx)
      ST_IDLE: begin
        // launch, if any, was decided above
      end
      ST_HIGH: begin
        if (txReady) begin
          s_nxt.tx = ST_LOW;
        end
      end
      ST_LOW: begin
        // no buffer: a word landing mid-send changes this low byte
        if (txReady) begin
          s_nxt.tx = ST_IDLE;
        end
      end
      default: begin
        s_nxt.tx = ST_IDLE;
      end
    endcase

    // ahb data phase
    if (s_r.aValid && s_r.aWrite) begin
      if (s_r.aAddr == OFS_CTRL) begin
        s_nxt.ctrl = hwdata[CTRL_W-1:0];
      end else if (s_r.aAddr == OFS_SIMVAL) begin
        s_nxt.simVal = hwdata[15:0];
      end else if (s_r.aAddr == OFS_SUBVAL) begin
        s_nxt.subVal = hwdata[15:0];
      end else if (s_r.aAddr == OFS_LIMLO) begin
        s_nxt.limLo = hwdata[15:0];
      end else if (s_r.aAddr == OFS_START) begin
        s_nxt.startPt = hwdata[15:0];
      end else if (s_r.aAddr == OFS_END) begin
        s_nxt.endPt = hwdata[15:0];
      end else if (s_r.aAddr == OFS_LIMHI) begin
        s_nxt.limHi = hwdata[15:0];
      end else if (s_r.aAddr == OFS_FCLR) begin
        s_nxt.clrCnt = hwdata[15:0];
      end else if (s_r.aAddr == OFS_CJRATIO) begin
        s_nxt.cjRatio = hwdata[15:0];
      end else if (s_r.aAddr == OFS_IRQST) begin
        s_nxt.irqSt = s_r.irqSt & ~hwdata[IRQ_W-1:0];
      end else if (s_r.aAddr == OFS_IRQMSK) begin
        s_nxt.irqMsk = hwdata[IRQ_W-1:0];
      end
    end
    // set wins over write-one clear
    s_nxt.irqSt = s_nxt.irqSt | irqEv;

    // address phase latched here; its data phase is the next cycle
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      s_nxt.aValid = 1'b1;
      s_nxt.aWrite = hwrite;
      s_nxt.aAddr = haddr[7:0];
    end else begin
      s_nxt.aValid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{
        ctrl: '0,
        simVal: 16'h0000,
        subVal: 16'h0000,
        limLo: DEF_LIMLO,
        startPt: DEF_START,
        endPt: DEF_END,
        limHi: DEF_LIMHI,
        clrCnt: DEF_FCLR,
        cjRatio: DEF_CJRATIO,
        tcCount: 16'h0000,
        goodCnt: 16'h0000,
        faulted: 1'b0,
        lastGood: DEF_START,
        word: 16'h0000,
        irqSt: '0,
        irqMsk: '0,
        tx: ST_IDLE,
        cjReq: 1'b0,
        aValid: 1'b0,
        aWrite: 1'b0,
        aAddr: 8'h00
      };
    end else if (clkEn) begin
      // low enable also freezes the bus slave while hreadyout stays high: masters must idle then
      s_r <= s_nxt;
    end
  end

  // zero wait states: read data is decoded from the latched address
  assign hrdata = s_r.aValid ? regRd : 32'h0000_0000;
  // every register answers at once, so no wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign txValid = (s_r.tx != ST_IDLE);
  assign txByte = (s_r.tx == ST_HIGH) ? s_r.word[15:8] : s_r.word[7:0];
  assign chanWord = s_r.word;
  assign chanActive = active;
  assign cjRequest = s_r.cjReq;
  assign cjExternal = s_r.ctrl[CTRL_CJEXT];
  // per-source gating, then one level output
  logic [IRQ_W-1:0] irqLive;
  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
    assign irqLive[i] = s_r.irqSt[i] & s_r.irqMsk[i];
  end
  assign irq = |irqLive;
endmodule : tcv_value_path
`default_nettype wire

/* File: sim/tcv_value_path_sva.sv */
// port assertions for the channel value path
`timescale 1ns/10ps
`default_nettype none
module tcv_value_path_chk
  import tcv_pkg::*;
#(
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // front end
  input wire logic measValid,
  input wire logic measIsCj,
  input wire logic cjRequest,
  input wire logic cjExternal,
  input wire logic chanActive,
  // byte stream
  input wire logic txReady,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  input wire logic [DW-1:0] chanWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_high_first: assert property (
    $rose(txValid) |-> txByte == chanWord[15:8]) else $error("high byte");
  chk_low_second: assert property (
    $rose(txValid) && txReady |=> txValid && txByte == $past(chanWord[7:0]))
    else $error("low byte");
  chk_byte_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txByte)) else $error("hold");
  chk_tx_launch: assert property (
    measValid && chanActive && !measIsCj && !txValid |=> txValid)
    else $error("no launch");
  chk_idle_word: assert property (
    measValid && !chanActive |=> $stable(chanWord)) else $error("inactive");
  chk_cj_skip: assert property (
    measValid && measIsCj |=> $stable(chanWord)) else $error("cj word");
  chk_cj_clear: assert property (
    measValid && measIsCj && chanActive |=> !cjRequest) else $error("cj req");
  chk_ext_quiet: assert property (
    cjExternal && !cjRequest |=> !cjRequest) else $error("ext cj");
  cov_stall: cover property ($rose(txValid) && !txReady);
  cov_cj: cover property ($fell(cjRequest));
  cov_idle: cover property (measValid && !chanActive);
endmodule : tcv_value_path_chk
bind tcv_value_path tcv_value_path_chk #(.DW(DW)) chk (.clk, .rst,
  .measValid, .measIsCj, .cjRequest, .cjExternal, .chanActive, .txReady,
  .txValid, .txByte, .chanWord);
`default_nettype wire

/* File: sim/tcv_com_sink.sv */
// com unit model gathering channel words from the byte stream
`timescale 1ns/10ps
`default_nettype none
module tcv_com_sink (
  // clock, reset and stall control
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  // byte stream
  input wire logic txValid,
  input wire logic [7:0] txByte,
  output logic txReady,
  // gathered words
  output logic [15:0] rxWord,
  output int nWords
);
  logic gotHigh;
  logic [7:0] highByte;
  logic [1:0] phase;
  // a slow unit takes one byte in four cycles
  assign txReady = !slow || phase == 2'h3;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {gotHigh, highByte, phase, rxWord, nWords} <= '0;
    end else begin
      phase <= phase + 2'h1;
      if (txValid && txReady) begin
        gotHigh <= !gotHigh;
        highByte <= txByte;
        if (gotHigh) {rxWord, nWords} <= {highByte, txByte, nWords + 1};
      end
    end
  end
endmodule : tcv_com_sink
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the channel value path
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tcv_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, measValid;
  logic measIsCj, lineFault, txReady, txValid, cjRequest, cjExternal;
  logic chanActive, irq, slow;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans;
  logic [7:0] txByte;
  logic [15:0] measPct, chanWord, rxWord, expW;
  int nWords, errCount, numChecks, mode, cc, lg, sim, sub, fclr;
  int st = 10000, en = 50000, lo = 0, hi = 60000;
  bit flt, lfd, simOn, act, cjx;
  logic [7:0] ra[7] = '{OFS_LIMLO, OFS_START, OFS_END, OFS_LIMHI, OFS_FCLR,
    OFS_CJRATIO, 8'h40};
  logic [15:0] rv[7] = '{DEF_LIMLO, DEF_START, DEF_END, DEF_LIMHI, DEF_FCLR,
    DEF_CJRATIO, 16'h0};
  tcv_value_path uut (.clk, .rst, .clkEn(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .measValid, .measPct, .measIsCj, .lineFault, .cjRequest, .cjExternal,
    .txReady, .txValid, .txByte, .chanWord, .chanActive, .irq);
  tcv_com_sink sink (.clk, .rst, .slow, .txValid, .txByte, .txReady,
    .rxWord, .nWords);
  assign hready = hreadyout;
  task ck(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : ck
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {hsel, htrans, haddr, hwrite} <=
      {1'b1, HTRANS_NONSEQ, 24'h0, a, w};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do begin
      @(negedge clk) rd = hrdata;
      @(posedge clk);
    end while (hreadyout !== 1'b1);
  endtask : ahb
  task ctl();
    ahb(1'b1, OFS_CTRL, {26'h0, act, cjx, lfd, mode[1:0], simOn});
  endtask : ctl
  function int sc(input int p);
    longint v;
    v = st + (longint'(en - st) * p) / 32768;
    return int'(v < lo ? lo : v > hi ? hi : v);
  endfunction : sc
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task mdl(input int p, input bit f);
    int v;
    bit e;
    // fault stays an error through the sample that clears it
    e = lfd && (f || flt);
    v = simOn ? sc(sim) : !e || mode == 0 ? sc(p) : mode == 1 ? sc(sub) : lg;
    if (lfd && f) {flt, cc} = {1'b1, 32'h0};
    else if (!flt) lg = sc(p);
    else if (++cc >= (fclr < 2 ? 1 : fclr)) flt = 1'b0;
    expW = v[15:0];
    // status nibble only inside nominal span
    if (st >= 10000 && en <= 50000)
      expW[3:0] = {2'b00, e, e && mode != 0 && !simOn};
  endtask : mdl
  task smp(input logic [15:0] p, input logic f, input logic c);
    int n0;
    n0 = nWords;
    @(posedge clk) {measValid, measPct, lineFault, measIsCj} <= {1'b1, p, f, c};
    @(posedge clk) measValid <= 1'b0;
    if (act && !c) begin
      mdl(p, f);
      @(negedge clk) ck("chanWord", expW, chanWord);
      for (int k = 0; k < 99 && nWords == n0; k++) @(posedge clk);
      ck("rxWord", expW, rxWord);
    end else begin
      repeat (9) @(posedge clk);
      ck("nWords", n0, nWords);
    end
  endtask : smp
  task wrapUp();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrapUp
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    errCount++;
    wrapUp();
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, slow} = '0;
    {measValid, measPct, measIsCj, lineFault} = '0;
    {rst, act, seed} = {2'b11, 32'h897CAA67};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      ahb(1'b0, ra[i], 32'h0);
      ck("reg", rv[i], rd);
    end
    ctl();
    smp(16'h0, 1'b0, 1'b0);
    smp(16'h8000, 1'b0, 1'b0);
    smp(16'hC000, 1'b0, 1'b0);
    slow <= 1'b1;
    repeat (8) begin
      seed = lfsr(seed);
      smp(16'(seed[7:0] % 13) << 12, seed[8], 1'b0);
    end
    $display("done scaling");
    slow <= 1'b0;
    {lo, hi} = {32'h4E20, 32'h9C40};
    ahb(1'b1, OFS_LIMLO, 32'h4E20);
    ahb(1'b1, OFS_LIMHI, 32'h9C40);
    smp(16'h0, 1'b0, 1'b0);
    smp(16'h8000, 1'b0, 1'b0);
    ahb(1'b1, OFS_SIMVAL, 32'h4000);
    {sim, simOn} = {32'h4000, 1'b1};
    ctl();
    smp(16'h1000, 1'b0, 1'b0);
    $display("done limits");
    ahb(1'b1, OFS_SUBVAL, 32'h6000);
    ahb(1'b1, OFS_FCLR, 32'h3);
    {sub, fclr, lfd, simOn} = {32'h6000, 32'h3, 2'b10};
    for (mode = 0; mode < 3; mode++) begin
      ctl();
      smp(16'h4000, 1'b0, 1'b0);
      smp(16'h1000, 1'b1, 1'b0);
      repeat (3) smp(16'h2000, 1'b0, 1'b0);
    end
    $display("done faults");
    {mode, lfd, st} = '0;
    ahb(1'b1, OFS_START, 32'h0);
    smp(16'h5000, 1'b0, 1'b0);
    ahb(1'b1, OFS_CJRATIO, 32'h3);
    for (int x = 0; x < 2; x++) begin
      cjx = x[0];
      ctl();
      @(negedge clk) ck("cjExternal", cjx, cjExternal);
      smp(16'h0, 1'b0, 1'b1);
      ck("cjRequest", 0, cjRequest);
      repeat (3) smp(16'h2000, 1'b0, 1'b0);
      ck("cjRequest", !cjx, cjRequest);
    end
    $display("done cold junction");
    act = 1'b0;
    ctl();
    @(negedge clk) ck("chanActive", 0, chanActive);
    smp(16'h3000, 1'b0, 1'b0);
    act = 1'b1;
    ctl();
    ahb(1'b1, OFS_IRQST, 32'h7);
    ahb(1'b1, OFS_IRQMSK, 32'h4);
    smp(16'h0, 1'b0, 1'b0);
    @(negedge clk) ck("irq", 1, irq);
    ahb(1'b0, OFS_IRQST, 32'h0);
    ck("irqStatus", 4, rd);
    ahb(1'b1, OFS_IRQST, 32'h4);
    @(negedge clk) ck("irq", 0, irq);
    ahb(1'b1, OFS_IRQMSK, 32'h0);
    smp(16'h0, 1'b0, 1'b0);
    @(negedge clk) ck("irq", 0, irq);
    $display("done interrupts");
    wrapUp();
  end
endmodule : tb_top
`default_nettype wire
